/* File: common/adc_seq_consts.vh */
/*
 * Constants for the converter mode sequencer: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define OFS_START_CTRL 6'h04
`define OFS_CONVERTER_CONTROL 6'h08
`define OFS_CHANNEL_SELECT 6'h0c
`define OFS_CONVERSION_MODE 6'h10
`define OFS_SCAN_RANGE 6'h14
`define OFS_CONVERSION_STATUS 6'h18

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define BIT_NORMAL_START 0
`define BIT_PRIORITY_START 1
`define BIT_ANALOG_CIRCUIT_POWER 7
`define BIT_IDLE_RUN_ENABLE 6
`define BIT_REFERENCE_ALWAYS_ON 5
`define BIT_PRIORITY_HW_SOURCE_SEL 3
`define BIT_PRIORITY_HW_TRIGGER_EN 2
`define BIT_NORMAL_HW_SOURCE_SEL 1
`define BIT_NORMAL_HW_TRIGGER_EN 0
`define BIT_REPEAT 1
`define BIT_SCAN 0
`define BIT_PRIORITY_DONE 3
`define BIT_PRIORITY_BUSY 2
`define BIT_NORMAL_DONE 1
`define BIT_NORMAL_BUSY 0

// -----------------------------------------------------------------------------
// Reset values and write masks
// -----------------------------------------------------------------------------
`define RST_CONVERTER_CONTROL 8'h00
`define RST_CHANNEL_SELECT 8'h00
`define RST_CONVERSION_MODE 8'h00
`define RST_SCAN_RANGE 8'h00
`define MASK_CONVERTER_CONTROL 8'hef
`define MASK_CONVERSION_MODE 8'h73

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define CONV_TIME_NS 4000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: logic/trigger_edge_sync.v */
/*
 * Three-stage synchroniser for an active-low trigger pin with a falling-edge
 * pulse output.
 * Assumes the pin is asynchronous to core_clk_in.
 */
`timescale 1ns/1ps

module trigger_edge_sync (
	input wire core_clk_in,
	input wire reset_n_in,
	input wire pin_n_in,
	output wire fall_pulse_out
);

	reg meta_reg;
	reg sync_a_reg;
	reg sync_b_reg;
	reg level_reg;

	// Resets high so that an idle pin gives no edge after reset.
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_reg <= 1'b1;
			sync_a_reg <= 1'b1;
			sync_b_reg <= 1'b1;
			level_reg <= 1'b1;
		end else begin
			meta_reg <= pin_n_in;
			sync_a_reg <= meta_reg;
			sync_b_reg <= sync_a_reg;
			level_reg <= sync_b_reg;
		end
	end

	// A fall counts once the second and third stages agree low after a high level.
	assign fall_pulse_out = ~sync_a_reg & ~sync_b_reg & level_reg;

endmodule // trigger_edge_sync

/* File: logic/adc_mode_sequencer.v */
/*
 * Mode and status control for an 8-input sequential converter: control,
 * channel, mode, scan and status registers, trigger selection, conversion
 * sequencing and completion events.
 * Assumes a single-cycle register port on core_clk_in and an analog core whose
 * busy time is modelled by a fixed cycle count.
 * Assumes software keeps the trigger pin on one conversion kind only and keeps
 * the scan range inside the eight inputs; neither is guarded here.
 */
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

// Function
// - Control bit 7 powers the analog circuit on or off.
// - Control bit 6 lets conversion continue during system idle.
// - Control bit 5 keeps reference current on except in reset.
// - Control bit 3 picks priority hardware source: pin or internal trigger.
// - Control bit 2 enables priority hardware starts.
// - Control bit 1 picks normal hardware source: pin or internal trigger.
// - Control bit 0 enables normal hardware starts.
// - Channel register: bits 7-4 priority input, bits 3-0 normal input.
// - Mode bit 1 selects single or repeated normal conversion.
// - Mode bit 0 selects fixed channel or channel scan.
// - Fixed repeat mode fires completion every interval-plus-one conversions.
// - Interval field counts only in fixed-channel repeat mode.
// - Clearing repeat stops repeated conversion; software changes only that bit.
// - Scan converts count-plus-one ascending inputs from the first channel.
// - Status bit 3 shows priority conversion completed.
// - Status bit 2 shows priority conversion in progress.
// - Status bit 1 shows normal conversion completed.
// - Status bit 0 shows normal conversion in progress.
// - Reading status clears both completion flags.
// - Simultaneous starts: priority starts, normal request is discarded.
module adc_mode_sequencer #(
	parameter CONV_CYCLES = `CONV_CYCLES
) (
	input wire core_clk_in,
	input wire reset_n_in,
	input wire [5:0] reg_addr_in,
	input wire reg_write_in,
	input wire reg_read_in,
	input wire [31:0] reg_wdata_in,
	output reg [31:0] reg_rdata_out,
	input wire external_trigger_pin_n_in,
	input wire priority_internal_trigger_in,
	input wire normal_internal_trigger_in,
	input wire system_idle_in,
	output reg analog_circuit_power_out,
	output reg reference_current_on_out,
	output reg [2:0] convert_channel_out,
	output reg sample_active_out,
	output reg normal_done_pulse_out,
	output reg normal_irq_pulse_out,
	output reg priority_done_pulse_out
);

	// -------------------------------------------------------------------------
	// Registers and states
	// -------------------------------------------------------------------------
	// Sequencer states; a priority conversion may interrupt a normal one.
	localparam ST_IDLE = 2'h0;
	localparam ST_NORMAL = 2'h1;
	localparam ST_PRIORITY = 2'h2;

	reg [7:0] converter_control_reg;
	reg [7:0] channel_select_reg;
	reg [7:0] conversion_mode_reg;
	reg [7:0] scan_range_reg;
	reg priority_done_flag_reg;
	reg priority_busy_flag_reg;
	reg normal_done_flag_reg;
	reg normal_busy_flag_reg;
	reg [1:0] state_reg;
	reg [15:0] timer_reg;
	reg [2:0] scan_index_reg;
	reg [2:0] interval_count_reg;
	reg normal_pending_reg;

	wire pin_fall;

	// The pin is asynchronous, so an edge is taken only after the stages agree.
	trigger_edge_sync pin_sync (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.pin_n_in(external_trigger_pin_n_in),
		.fall_pulse_out(pin_fall)
	);

	// -------------------------------------------------------------------------
	// Decoded fields
	// -------------------------------------------------------------------------
	wire power_on = converter_control_reg[`BIT_ANALOG_CIRCUIT_POWER];
	wire idle_run_enable = converter_control_reg[`BIT_IDLE_RUN_ENABLE];
	wire reference_always_on = converter_control_reg[`BIT_REFERENCE_ALWAYS_ON];
	wire priority_hw_source_sel = converter_control_reg[`BIT_PRIORITY_HW_SOURCE_SEL];
	wire priority_hw_trigger_en = converter_control_reg[`BIT_PRIORITY_HW_TRIGGER_EN];
	wire normal_hw_source_sel = converter_control_reg[`BIT_NORMAL_HW_SOURCE_SEL];
	wire normal_hw_trigger_en = converter_control_reg[`BIT_NORMAL_HW_TRIGGER_EN];
	// Only the low three bits of a channel code reach the channel output.
	wire [3:0] priority_channel_sel = channel_select_reg[7:4];
	wire [3:0] normal_channel_sel = channel_select_reg[3:0];
	wire repeat_mode = conversion_mode_reg[`BIT_REPEAT];
	wire scan_mode = conversion_mode_reg[`BIT_SCAN];
	wire [2:0] repeat_irq_interval = conversion_mode_reg[6:4];
	wire [3:0] scan_first_channel = scan_range_reg[3:0];
	wire [3:0] scan_channel_count = scan_range_reg[7:4];

	// Idle stalls the sequencer unless idle running is enabled.
	wire run_allowed = power_on & (~system_idle_in | idle_run_enable);

	// -------------------------------------------------------------------------
	// Start requests
	// -------------------------------------------------------------------------
	wire wr_start = reg_write_in & (reg_addr_in == `OFS_START_CTRL);
	// Hardware starts count only while their enable bit is set.
	wire priority_hw_start = priority_hw_trigger_en &
		(priority_hw_source_sel ? priority_internal_trigger_in : pin_fall);
	wire normal_hw_start = normal_hw_trigger_en &
		(normal_hw_source_sel ? normal_internal_trigger_in : pin_fall);
	wire priority_req = (wr_start & reg_wdata_in[`BIT_PRIORITY_START]) | priority_hw_start;
	// A normal request in the same cycle as a priority one is dropped, not held.
	wire normal_req = ((wr_start & reg_wdata_in[`BIT_NORMAL_START]) | normal_hw_start) &
		~priority_req;

	wire timer_done = (timer_reg == 16'h0000) & run_allowed;
	wire [3:0] scan_last = scan_first_channel + scan_channel_count;
	// Compared at four bits so that a scan ending on input 7 cannot wrap.
	wire scan_at_end = ({1'b0, scan_index_reg} >= scan_last);
	wire rd_status = reg_read_in & (reg_addr_in == `OFS_CONVERSION_STATUS);
	// The timer counts down to zero, so it is loaded with one less than the count.
	wire [15:0] conv_load = CONV_CYCLES[15:0] - 16'h0001;

	// -------------------------------------------------------------------------
	// Register writes
	// -------------------------------------------------------------------------
	// Write data above bit 7 is ignored; every register here is eight bits wide.
	// Reserved bits are masked on write so that they always read back as zero.
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			converter_control_reg <= `RST_CONVERTER_CONTROL;
			channel_select_reg <= `RST_CHANNEL_SELECT;
			conversion_mode_reg <= `RST_CONVERSION_MODE;
			scan_range_reg <= `RST_SCAN_RANGE;
		end else if (reg_write_in) begin
			case (reg_addr_in)
				`OFS_CONVERTER_CONTROL: begin
					converter_control_reg <= reg_wdata_in[7:0] & `MASK_CONVERTER_CONTROL;
				end
				`OFS_CHANNEL_SELECT: begin
					channel_select_reg <= reg_wdata_in[7:0];
				end
				`OFS_CONVERSION_MODE: begin
					conversion_mode_reg <= reg_wdata_in[7:0] & `MASK_CONVERSION_MODE;
				end
				`OFS_SCAN_RANGE: begin
					scan_range_reg <= reg_wdata_in[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// Conversion sequencer
	// -------------------------------------------------------------------------
	// One conversion runs at a time; the timer counts run cycles down to zero.
	// Idle without idle running holds the timer, so a conversion resumes later.
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= ST_IDLE;
			timer_reg <= 16'h0000;
			scan_index_reg <= 3'h0;
			interval_count_reg <= 3'h0;
			normal_pending_reg <= 1'b0;
			priority_busy_flag_reg <= 1'b0;
			normal_busy_flag_reg <= 1'b0;
			priority_done_flag_reg <= 1'b0;
			normal_done_flag_reg <= 1'b0;
			convert_channel_out <= 3'h0;
			sample_active_out <= 1'b0;
			normal_done_pulse_out <= 1'b0;
			normal_irq_pulse_out <= 1'b0;
			priority_done_pulse_out <= 1'b0;
		end else begin
			// Event pulses last a single cycle.
			normal_done_pulse_out <= 1'b0;
			normal_irq_pulse_out <= 1'b0;
			priority_done_pulse_out <= 1'b0;
			// Reading status clears; a completion in the same cycle wins.
			if (rd_status) begin
				priority_done_flag_reg <= 1'b0;
				normal_done_flag_reg <= 1'b0;
			end
			case (state_reg)
				ST_IDLE: begin
					// Priority is checked first, so a pending normal conversion waits.
					if (priority_req & power_on) begin
						state_reg <= ST_PRIORITY;
						timer_reg <= conv_load;
						convert_channel_out <= priority_channel_sel[2:0];
						sample_active_out <= 1'b1;
						priority_busy_flag_reg <= 1'b1;
						priority_done_flag_reg <= 1'b0;
					end else if ((normal_req | normal_pending_reg) & power_on) begin
						state_reg <= ST_NORMAL;
						timer_reg <= conv_load;
						normal_pending_reg <= 1'b0;
						scan_index_reg <= scan_first_channel[2:0];
						convert_channel_out <= scan_mode ? scan_first_channel[2:0] :
							normal_channel_sel[2:0];
						interval_count_reg <= 3'h0;
						sample_active_out <= 1'b1;
						normal_busy_flag_reg <= 1'b1;
						normal_done_flag_reg <= 1'b0;
					end
				end
				ST_NORMAL: begin
					if (run_allowed & (timer_reg != 16'h0000)) begin
						timer_reg <= timer_reg - 16'h0001;
					end
					// A priority request preempts; the normal conversion restarts from its start afterward.
					if (priority_req) begin
						state_reg <= ST_PRIORITY;
						timer_reg <= conv_load;
						normal_pending_reg <= 1'b1;
						convert_channel_out <= priority_channel_sel[2:0];
						priority_busy_flag_reg <= 1'b1;
						priority_done_flag_reg <= 1'b0;
					end else if (timer_done) begin
						normal_done_pulse_out <= 1'b1;
						if (scan_mode & ~scan_at_end) begin
							scan_index_reg <= scan_index_reg + 3'h1;
							convert_channel_out <= scan_index_reg + 3'h1;
							timer_reg <= conv_load;
						// Clearing repeat lets the current pass finish and then stops.
						end else if (repeat_mode) begin
							if (~scan_mode) begin
								if (interval_count_reg == repeat_irq_interval) begin
									interval_count_reg <= 3'h0;
									normal_irq_pulse_out <= 1'b1;
									normal_done_flag_reg <= 1'b1;
								end else begin
									interval_count_reg <= interval_count_reg + 3'h1;
								end
							end else begin
								normal_irq_pulse_out <= 1'b1;
								normal_done_flag_reg <= 1'b1;
							end
							scan_index_reg <= scan_first_channel[2:0];
							convert_channel_out <= scan_mode ? scan_first_channel[2:0] :
								normal_channel_sel[2:0];
							timer_reg <= conv_load;
						end else begin
							state_reg <= ST_IDLE;
							sample_active_out <= 1'b0;
							normal_irq_pulse_out <= 1'b1;
							normal_done_flag_reg <= 1'b1;
							normal_busy_flag_reg <= 1'b0;
						end
					end
				end
				ST_PRIORITY: begin
					if (run_allowed & (timer_reg != 16'h0000)) begin
						timer_reg <= timer_reg - 16'h0001;
					end
					// A normal request during a priority conversion is started afterward.
					if (normal_req) begin
						normal_pending_reg <= 1'b1;
					end
					if (timer_done) begin
						state_reg <= ST_IDLE;
						sample_active_out <= 1'b0;
						priority_done_pulse_out <= 1'b1;
						priority_done_flag_reg <= 1'b1;
						priority_busy_flag_reg <= 1'b0;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
			// Losing power aborts any conversion in progress.
			if (~power_on) begin
				state_reg <= ST_IDLE;
				sample_active_out <= 1'b0;
				normal_pending_reg <= 1'b0;
				normal_busy_flag_reg <= 1'b0;
				priority_busy_flag_reg <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Analog power outputs
	// -------------------------------------------------------------------------
	// Reference current follows the sequencer unless it is held on throughout.
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			analog_circuit_power_out <= 1'b0;
			reference_current_on_out <= 1'b0;
		end else begin
			analog_circuit_power_out <= power_on;
			reference_current_on_out <= reference_always_on | (state_reg != ST_IDLE);
		end
	end

	// -------------------------------------------------------------------------
	// Status word
	// -------------------------------------------------------------------------
	// Done flags stay set until a status read or a new start of their kind; busy follows the sequencer.
	wire [3:0] status_bits = {
		priority_done_flag_reg,
		priority_busy_flag_reg,
		normal_done_flag_reg,
		normal_busy_flag_reg
	};

	// -------------------------------------------------------------------------
	// Register read
	// -------------------------------------------------------------------------
	// Read data is registered and holds until the next read.
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (reg_read_in) begin
			case (reg_addr_in)
				`OFS_CONVERTER_CONTROL: reg_rdata_out <= {24'h000000, converter_control_reg};
				`OFS_CHANNEL_SELECT: reg_rdata_out <= {24'h000000, channel_select_reg};
				`OFS_CONVERSION_MODE: reg_rdata_out <= {24'h000000, conversion_mode_reg};
				`OFS_SCAN_RANGE: reg_rdata_out <= {24'h000000, scan_range_reg};
				`OFS_CONVERSION_STATUS: reg_rdata_out <= {28'h0000000, status_bits};
				default: reg_rdata_out <= 32'h00000000;
			endcase
		end
	end

endmodule // adc_mode_sequencer

/* File: tb/adc_seq_checker.sv */
/* Concurrent checks for the converter mode sequencer.
   Assumes binding to adc_mode_sequencer; sees only its ports. */
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_seq_checker #(parameter CONV_CYCLES = 40) (
	input wire core_clk_in,
	input wire reset_n_in,
	input wire [5:0] reg_addr_in,
	input wire reg_write_in,
	input wire reg_read_in,
	input wire [31:0] reg_wdata_in,
	input wire system_idle_in,
	input wire [31:0] reg_rdata_out,
	input wire analog_circuit_power_out,
	input wire reference_current_on_out,
	input wire [2:0] convert_channel_out,
	input wire sample_active_out,
	input wire normal_done_pulse_out,
	input wire normal_irq_pulse_out,
	input wire priority_done_pulse_out
);
	reg [7:0] ctrl_reg, chan_reg, mode_reg, run_reg;
	reg [2:0] cnt_reg;
	wire [5:0] a = reg_addr_in;
	wire rd = reg_read_in;
	wire wm = reg_write_in && a == `OFS_CONVERSION_MODE;
	wire go = reg_write_in && a == `OFS_START_CTRL && |reg_wdata_in[1:0];
	wire ok = !sample_active_out && !system_idle_in && ctrl_reg[7];
	// --------
	// Shadow registers and counters
	// --------
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_reg <= 8'h00;
			chan_reg <= 8'h00;
			mode_reg <= 8'h00;
			run_reg <= 8'h00;
			cnt_reg <= 3'h0;
		end else begin
			if (reg_write_in && a == `OFS_CONVERTER_CONTROL)
				ctrl_reg <= reg_wdata_in[7:0] & `MASK_CONVERTER_CONTROL;
			if (reg_write_in && a == `OFS_CHANNEL_SELECT)
				chan_reg <= reg_wdata_in[7:0];
			if (wm)
				mode_reg <= reg_wdata_in[7:0] & `MASK_CONVERSION_MODE;
			if (!sample_active_out)
				run_reg <= 8'h00;
			else if (run_reg != 8'hff)
				run_reg <= run_reg + 8'h01;
			if (normal_irq_pulse_out || wm)
				cnt_reg <= 3'h0;
			else if (normal_done_pulse_out)
				cnt_reg <= cnt_reg + 3'h1;
		end
	end
	// --------
	// Properties
	// --------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_stat_rd;
		rd && a == `OFS_CONVERSION_STATUS;
	endsequence
	sequence s_quiet;
		!normal_irq_pulse_out && !priority_done_pulse_out;
	endsequence
	property p_power;
		analog_circuit_power_out == $past(ctrl_reg[7]);
	endproperty
	a_power: assert property (p_power) else $error("power output wrong");
	property p_ctrl_rd;
		rd && a == `OFS_CONVERTER_CONTROL |=> reg_rdata_out == {24'h0, $past(ctrl_reg)};
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
	property p_mode_rd;
		rd && a == `OFS_CONVERSION_MODE |=> reg_rdata_out == {24'h0, $past(mode_reg)};
	endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
	property p_ref;
		$past(ctrl_reg[5]) |-> reference_current_on_out;
	endproperty
	a_ref: assert property (p_ref) else $error("reference current off");
	property p_no_hw;
		!sample_active_out && !$past(sample_active_out) && !go && !ctrl_reg[2] && !ctrl_reg[0]
			&& !priority_done_pulse_out && !$past(priority_done_pulse_out) |=> !sample_active_out;
	endproperty
	a_no_hw: assert property (p_no_hw) else $error("start without request");
	property p_prio;
		go && reg_wdata_in[1] && ok |=>
			sample_active_out && convert_channel_out == $past(chan_reg[6:4]);
	endproperty
	a_prio: assert property (p_prio) else $error("priority start wrong");
	property p_nchan;
		go && reg_wdata_in[1:0] == 2'b01 && ok && !mode_reg[0] |=>
			convert_channel_out == $past(chan_reg[2:0]);
	endproperty
	a_nchan: assert property (p_nchan) else $error("normal channel wrong");
	property p_len;
		normal_done_pulse_out || priority_done_pulse_out |-> run_reg >= CONV_CYCLES;
	endproperty
	a_len: assert property (p_len) else $error("conversion too short");
	property p_itm;
		normal_irq_pulse_out && mode_reg[1:0] == 2'b10 |-> cnt_reg == mode_reg[6:4];
	endproperty
	a_itm: assert property (p_itm) else $error("repeat interval wrong");
	property p_single;
		normal_done_pulse_out && mode_reg[1:0] == 2'b00 |-> normal_irq_pulse_out;
	endproperty
	a_single: assert property (p_single) else $error("single completion missed");
	property p_clear;
		s_stat_rd ##1 s_quiet ##1 (s_stat_rd ##0 s_quiet) |=> !reg_rdata_out[3] && !reg_rdata_out[1];
	endproperty
	a_clear: assert property (p_clear) else $error("done flag not cleared");
endmodule // adc_seq_checker

bind adc_mode_sequencer adc_seq_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
	.core_clk_in, .reset_n_in, .reg_addr_in, .reg_write_in, .reg_read_in, .reg_wdata_in,
	.system_idle_in, .reg_rdata_out, .analog_circuit_power_out, .reference_current_on_out,
	.convert_channel_out, .sample_active_out, .normal_done_pulse_out, .normal_irq_pulse_out,
	.priority_done_pulse_out
);

/* File: tb/tb.sv */
/* Self-checking bench for the converter mode sequencer.
   Assumes the sequencer and its bound checker are compiled with it. */
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module tb;
	localparam CC = 4;
	reg core_clk_in = 1'b0;
	reg reset_n_in = 1'b0;
	reg [5:0] reg_addr_in = 6'h00;
	reg reg_write_in = 1'b0;
	reg reg_read_in = 1'b0;
	reg [31:0] reg_wdata_in = 32'h0;
	reg pin_n = 1'b1;
	reg trig = 1'b0;
	reg idle = 1'b0;
	wire [31:0] rdata;
	wire pwr, ref_on, act, n_done, n_irq, p_done;
	wire [2:0] chan;
	integer errors = 0;
	integer tests_run = 0;
	integer cycles = 0;
	integer tnum = 0;
	integer i, k, st, ar, i2, seen_n, seen_p;
	reg [31:0] d, v;
	reg [2:0] c_prev;
	reg [13:0] hw_tab [0:4];
	adc_mode_sequencer #(.CONV_CYCLES(CC)) dut (
		.core_clk_in, .reset_n_in, .reg_addr_in, .reg_write_in, .reg_read_in, .reg_wdata_in,
		.reg_rdata_out(rdata), .external_trigger_pin_n_in(pin_n),
		.priority_internal_trigger_in(trig), .normal_internal_trigger_in(trig),
		.system_idle_in(idle), .analog_circuit_power_out(pwr),
		.reference_current_on_out(ref_on), .convert_channel_out(chan),
		.sample_active_out(act), .normal_done_pulse_out(n_done),
		.normal_irq_pulse_out(n_irq), .priority_done_pulse_out(p_done)
	);
	always #50 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			results;
		end
	end
	// --------
	// Tasks
	// --------
	task chk(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [5:0] a, input [31:0] x);
		begin
			@(negedge core_clk_in);
			reg_write_in = 1'b1;
			reg_addr_in = a;
			reg_wdata_in = x;
			@(negedge core_clk_in);
			reg_write_in = 1'b0;
		end
	endtask
	task rd(input [5:0] a, output [31:0] x);
		begin
			@(negedge core_clk_in);
			reg_read_in = 1'b1;
			reg_addr_in = a;
			@(negedge core_clk_in);
			reg_read_in = 1'b0;
			x = rdata;
		end
	endtask
	task fire(input [1:0] w);
		begin
			@(negedge core_clk_in);
			pin_n = ~w[0];
			trig = w[1];
			@(negedge core_clk_in);
			trig = 1'b0;
		end
	endtask
	// Counts completion events and releases the pin at the end.
	task watch(input integer n);
		begin
			seen_n = 0;
			seen_p = 0;
			repeat (n) begin
				@(negedge core_clk_in);
				seen_n = seen_n + n_irq;
				seen_p = seen_p + p_done;
			end
			pin_n = 1'b1;
		end
	endtask
	task next_done;
		begin
			i2 = 0;
			c_prev = chan;
			@(negedge core_clk_in);
			while (n_done !== 1'b1 && i2 < 4 * CC) begin
				c_prev = chan;
				@(negedge core_clk_in);
				i2 = i2 + 1;
			end
		end
	endtask
	task fin;
		begin
			tnum = tnum + 1;
			$display("test %0d finished", tnum);
		end
	endtask
	task results;
		begin
			$display("tests_run %0d errors %0d", tests_run, errors);
			if (errors == 0 && tests_run > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	function [31:0] rmask(input [5:0] a);
		case (a)
			`OFS_CONVERTER_CONTROL: rmask = 32'hef;
			`OFS_CONVERSION_MODE: rmask = 32'h73;
			`OFS_CHANNEL_SELECT, `OFS_SCAN_RANGE: rmask = 32'hff;
			default: rmask = 32'h0;
		endcase
	endfunction
	// --------
	// Main sequence
	// --------
	initial begin
		hw_tab[0] = {8'h89, 2'b10, 2'b01, 2'b10};
		hw_tab[1] = {8'h83, 2'b01, 2'b10, 2'b10};
		hw_tab[2] = {8'h86, 2'b10, 2'b01, 2'b01};
		hw_tab[3] = {8'h8c, 2'b01, 2'b10, 2'b01};
		hw_tab[4] = {8'h88, 2'b11, 2'b11, 2'b00};
		d = $urandom(53703);
		repeat (8) @(negedge core_clk_in);
		reset_n_in = 1'b1;
		for (i = 1; i < 8; i = i + 1) begin
			rd({i[3:0], 2'b00}, d);
			chk(d, 32'h0);
		end
		for (i = 0; i < 16; i = i + 1) begin
			k = 2 + $urandom % 4;
			v = $urandom & 32'hffffff7f;
			wr({k[3:0], 2'b00}, v);
			rd({k[3:0], 2'b00}, d);
			chk(d, v & rmask({k[3:0], 2'b00}));
		end
		wr(`OFS_CONVERTER_CONTROL, 32'h20);
		@(negedge core_clk_in);
		chk({pwr, ref_on}, 32'h1);
		wr(`OFS_CONVERTER_CONTROL, 32'h80);
		@(negedge core_clk_in);
		chk({pwr, ref_on}, 32'h2);
		fin;
		v = $urandom % 64;
		wr(`OFS_CHANNEL_SELECT, {24'h0, 1'b0, v[5:3], 1'b0, v[2:0]});
		wr(`OFS_CONVERSION_MODE, 32'h0);
		rd(`OFS_CONVERSION_STATUS, d);
		wr(`OFS_START_CTRL, 32'h1);
		rd(`OFS_CONVERSION_STATUS, d);
		chk(d, 32'h1);
		chk(chan, v[2:0]);
		watch(2 * CC);
		chk(seen_n, 1);
		rd(`OFS_CONVERSION_STATUS, d);
		chk(d, 32'h2);
		rd(`OFS_CONVERSION_STATUS, d);
		chk(d, 32'h0);
		wr(`OFS_START_CTRL, 32'h3);
		rd(`OFS_CONVERSION_STATUS, d);
		chk(d, 32'h4);
		chk(chan, v[5:3]);
		watch(3 * CC);
		chk(seen_n * 2 + seen_p, 1);
		rd(`OFS_CONVERSION_STATUS, d);
		chk(d, 32'h8);
		fin;
		idle = 1'b1;
		wr(`OFS_START_CTRL, 32'h1);
		watch(3 * CC);
		chk(seen_n, 0);
		idle = 1'b0;
		watch(3 * CC);
		chk(seen_n, 1);
		wr(`OFS_CONVERTER_CONTROL, 32'hc0);
		idle = 1'b1;
		wr(`OFS_START_CTRL, 32'h1);
		watch(3 * CC);
		chk(seen_n, 1);
		idle = 1'b0;
		fin;
		for (k = 0; k < 5; k = k + 1) begin
			v = hw_tab[k];
			wr(`OFS_CONVERTER_CONTROL, v[13:6]);
			fire(v[5:4]);
			watch(3 * CC);
			chk(seen_n * 2 + seen_p, 32'h0);
			fire(v[3:2]);
			watch(3 * CC);
			chk(seen_n * 2 + seen_p, v[1:0]);
		end
		fin;
		k = $urandom % 8;
		wr(`OFS_CONVERSION_MODE, {25'h0, k[2:0], 4'h2});
		wr(`OFS_START_CTRL, 32'h1);
		ar = 0;
		i = 0;
		while (n_irq !== 1'b1 && i < 20 * CC) begin
			@(negedge core_clk_in);
			ar = ar + n_done;
			i = i + 1;
		end
		chk(ar, k + 1);
		wr(`OFS_CONVERTER_CONTROL, 32'h0);
		fin;
		wr(`OFS_CONVERTER_CONTROL, 32'h80);
		st = $urandom % 8;
		ar = $urandom % (8 - st);
		wr(`OFS_SCAN_RANGE, {24'h0, ar[3:0], st[3:0]});
		wr(`OFS_CONVERSION_MODE, 32'h3);
		wr(`OFS_START_CTRL, 32'h1);
		for (k = 0; k < 2; k = k + 1) begin
			if (k == 1)
				wr(`OFS_CONVERSION_MODE, 32'h1);
			for (i = 0; i <= ar; i = i + 1) begin
				next_done;
				chk(c_prev, st + i);
				chk(n_irq, i == ar);
			end
		end
		watch(3 * CC);
		chk({seen_n[3:0], act}, 32'h0);
		fin;
		results;
	end
endmodule // tb
